// >>> rtl/exec_pkg.sv
// Constants for the nibble swap / xor / direction load execution block.
// Shared by the execution module and its bench.
package exec_pkg;
  localparam int          DATA_W        = 8;
  localparam int          INSN_W        = 14;
  localparam int          FADDR_W       = 7;
  // Opcode patterns and match masks
  localparam logic [13:0] SWAP_MASK     = 14'h3f00;
  localparam logic [13:0] SWAP_PAT      = 14'h0e00;
  localparam logic [13:0] XORF_MASK     = 14'h3f00;
  localparam logic [13:0] XORF_PAT      = 14'h0600;
  localparam logic [13:0] XORL_MASK     = 14'h3f00;
  localparam logic [13:0] XORL_PAT      = 14'h3a00;
  localparam logic [13:0] DIRL_MASK     = 14'h3ff8;
  localparam logic [13:0] DIRL_PAT      = 14'h0060;
  // Field positions
  localparam int          DEST_BIT      = 7;
  // Direction registers and their data-space addresses
  localparam int          NUM_DIR       = 3;
  localparam logic [2:0]  DIR_SEL_FIRST = 3'h5;
  localparam logic [2:0]  DIR_SEL_LAST  = 3'h7;
  localparam logic [6:0]  DIR_ADDR_BASE = 7'h05;
  localparam logic [7:0]  DIR_RESET     = 8'hff;
  localparam logic [7:0]  ACC_RESET     = 8'h00;
  localparam logic        ZERO_RESET    = 1'b0;
endpackage : exec_pkg

// >>> rtl/nibble_swap_xor_dir_exec.sv
// Execution datapath for nibble swap, xor with literal, xor with file
// register and direction register load; holds accumulator, zero flag and
// direction registers. Assumes one instruction per sys_clk edge when
// insn_valid is high, and a file register read port giving file_rdata
// combinationally for the address in the instruction.
// Behaviour
// RULE1 - Swap nibbles of addressed register, flags kept
// RULE2 - Swap result to accumulator or register
// RULE3 - Xor literal into accumulator, set zero
// RULE4 - Copy accumulator into direction register 5-7
// RULE5 - Direction registers readable, writable in data space
// RULE6 - Xor file register, set zero, steer
`timescale 1ns/10ps
`default_nettype none
module nibble_swap_xor_dir_exec
  import exec_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  wire logic                 insn_valid,
  input  wire logic [INSN_W-1:0]    insn,
  input  wire logic [DATA_W-1:0]    file_rdata,
  output logic      [FADDR_W-1:0]   file_addr,
  output logic                      file_we,
  output logic      [DATA_W-1:0]    file_wdata,
  input  wire logic                 data_we,
  input  wire logic [FADDR_W-1:0]   data_addr,
  input  wire logic [DATA_W-1:0]    data_wdata,
  output logic      [DATA_W-1:0]    data_rdata,
  output logic                      data_hit,
  output logic      [DATA_W-1:0]    working_accumulator,
  output logic                      zero_flag,
  output logic      [DATA_W-1:0]    dir_reg_0,
  output logic      [DATA_W-1:0]    dir_reg_1,
  output logic      [DATA_W-1:0]    dir_reg_2
);

  // Operation kinds after opcode decode
  typedef enum logic [2:0] {
    OP_NONE,
    OP_SWAP,
    OP_XOR_FILE,
    OP_XOR_LIT,
    OP_DIR_LOAD
  } op_kind_t;

  logic               rst_meta_q;
  logic               rst_meta_d;
  logic               rst_sync_q;
  logic               rst_sync_d;

  logic [DATA_W-1:0]  acc_q;
  logic [DATA_W-1:0]  acc_d;
  logic               zero_q;
  logic               zero_d;
  logic [DATA_W-1:0]  dir_q [NUM_DIR];
  logic [DATA_W-1:0]  dir_d [NUM_DIR];

  op_kind_t           op_kind;
  logic               swap_match;
  logic               xorf_match;
  logic               xorl_match;
  logic               dirl_match;
  logic               dir_sel_ok;
  logic               is_swap;
  logic               is_xorf;
  logic               is_xorl;
  logic               is_dirl;
  logic               dest_file;

  logic               file_op;
  logic               acc_load;
  logic               zero_load;
  logic [DATA_W-1:0]  lit_field;
  logic [3:0]         nib_lo;
  logic [3:0]         nib_hi;
  logic [DATA_W-1:0]  result;
  logic [2:0]         dir_sel;
  logic [NUM_DIR-1:0] load_hit;
  logic [NUM_DIR-1:0] addr_hit;
  logic [NUM_DIR-1:0] write_hit;

  // Reset release through two flops; assertion stays asynchronous
  always_comb begin
    rst_meta_d = 1'b1;
    rst_sync_d = rst_meta_q;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= rst_meta_d;
      rst_sync_q <= rst_sync_d;
    end
  end

  // Instruction fields
  assign dir_sel   = insn[2:0];
  assign dest_file = insn[DEST_BIT];
  assign lit_field = insn[DATA_W-1:0];
  assign file_addr = insn[FADDR_W-1:0];
  assign nib_lo    = file_rdata[3:0];
  assign nib_hi    = file_rdata[7:4];

  // Opcode matches before the valid qualifier
  assign swap_match = ((insn & SWAP_MASK) == SWAP_PAT);
  assign xorf_match = ((insn & XORF_MASK) == XORF_PAT);
  assign xorl_match = ((insn & XORL_MASK) == XORL_PAT);
  assign dirl_match = ((insn & DIRL_MASK) == DIRL_PAT);
  // Selects outside 5..7 are ignored, no register exists there
  assign dir_sel_ok = (dir_sel >= DIR_SEL_FIRST) && (dir_sel <= DIR_SEL_LAST); // RULE4

  // Patterns are disjoint, so the priority order never matters
  always_comb begin
    op_kind = OP_NONE;
    if (insn_valid) begin
      if (swap_match) begin
        op_kind = OP_SWAP;
      end else if (xorf_match) begin
        op_kind = OP_XOR_FILE;
      end else if (xorl_match) begin
        op_kind = OP_XOR_LIT;
      end else if (dirl_match && dir_sel_ok) begin
        op_kind = OP_DIR_LOAD;
      end
    end
  end

  assign is_swap = (op_kind == OP_SWAP);
  assign is_xorf = (op_kind == OP_XOR_FILE);
  assign is_xorl = (op_kind == OP_XOR_LIT);
  assign is_dirl = (op_kind == OP_DIR_LOAD);

  always_comb begin
    result = acc_q;
    case (op_kind)
      OP_SWAP: begin
        result = {nib_lo, nib_hi}; // RULE1
      end
      OP_XOR_FILE: begin
        result = acc_q ^ file_rdata; // RULE6
      end
      OP_XOR_LIT: begin
        result = acc_q ^ lit_field; // RULE3
      end
      // Other kinds pass the accumulator through unchanged
      default: begin
        result = acc_q;
      end
    endcase
  end

  // Swap and xor with file share the destination steering
  assign file_op    = is_swap || is_xorf;
  assign file_we    = file_op && dest_file; // RULE2
  assign file_wdata = result;
  assign acc_load   = (file_op && !dest_file) || is_xorl; // RULE2
  // Swap and load leave the flag alone
  assign zero_load  = is_xorf || is_xorl; // RULE3 RULE6

  always_comb begin
    acc_d  = acc_q;
    zero_d = zero_q;
    if (acc_load) begin
      acc_d = result;
    end
    if (zero_load) begin
      zero_d = (result == '0);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      acc_q  <= ACC_RESET;
      zero_q <= ZERO_RESET;
    end else begin
      acc_q  <= acc_d;
      zero_q <= zero_d;
    end
  end

  // Load instruction wins over a data-space write to the same register
  // in one cycle; the decoder should never issue both.
  for (genvar i = 0; i < NUM_DIR; i++) begin : g_dir
    localparam logic [2:0] SEL  = 3'(DIR_SEL_FIRST + 3'(i));
    localparam logic [6:0] ADDR = 7'(DIR_ADDR_BASE + 7'(i));
    assign load_hit[i]  = is_dirl && (dir_sel == SEL); // RULE4
    assign addr_hit[i]  = (data_addr == ADDR); // RULE5
    assign write_hit[i] = data_we && addr_hit[i];
    always_comb begin
      dir_d[i] = dir_q[i];
      if (load_hit[i]) begin
        dir_d[i] = acc_q; // RULE4
      end else if (write_hit[i]) begin
        dir_d[i] = data_wdata; // RULE5
      end
    end
    always_ff @(posedge sys_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
        dir_q[i] <= DIR_RESET;
      end else begin
        dir_q[i] <= dir_d[i];
      end
    end
  end

  // Unmapped addresses read back as zero
  always_comb begin
    data_rdata = '0;
    for (int j = 0; j < NUM_DIR; j++) begin
      if (addr_hit[j]) begin
        data_rdata = dir_q[j]; // RULE5
      end
    end
  end

  assign data_hit            = |addr_hit; // RULE5
  assign working_accumulator = acc_q;
  assign zero_flag           = zero_q;
  assign dir_reg_0           = dir_q[0];
  assign dir_reg_1           = dir_q[1];
  assign dir_reg_2           = dir_q[2];

endmodule : nibble_swap_xor_dir_exec
`default_nettype wire

// >>> verification/exec_monitor.sv
// Port checker for the execution block.
// Bound to the block; inputs carry the block's port names.
`timescale 1ns/10ps
`default_nettype none
module exec_monitor
  import exec_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        insn_valid,
  input wire logic        file_we,
  input wire logic        data_hit,
  input wire logic        zero_flag,
  input wire logic [13:0] insn,
  input wire logic [6:0]  data_addr,
  input wire logic [7:0]  file_rdata,
  input wire logic [7:0]  file_wdata,
  input wire logic [7:0]  data_rdata,
  input wire logic [7:0]  working_accumulator,
  input wire logic [7:0]  dir_reg_2
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic       sw, xf, xl, dl;
  logic [7:0] swp, xr;
  assign sw  = insn_valid && (insn & SWAP_MASK) == SWAP_PAT;
  assign xf  = insn_valid && (insn & XORF_MASK) == XORF_PAT;
  assign xl  = insn_valid && (insn & XORL_MASK) == XORL_PAT;
  assign dl  = insn_valid && (insn & DIRL_MASK) == DIRL_PAT;
  assign swp = {file_rdata[3:0], file_rdata[7:4]};
  assign xr  = working_accumulator ^ insn[7:0];
  chk_swap_back: assert property (sw && insn[7] |-> file_we && file_wdata == swp)
    else $error("swap writeback wrong");
  chk_swap_acc: assert property (sw && !insn[7] |=> working_accumulator == $past(swp)
    && $stable(zero_flag)) else $error("swap to accumulator wrong");
  chk_xor_lit: assert property (xl |=> working_accumulator == $past(xr)
    && zero_flag == ($past(xr) == 8'h00)) else $error("xor literal wrong");
  chk_xor_file: assert property (xf && insn[7] |-> file_we
    && file_wdata == (working_accumulator ^ file_rdata) ##1 $stable(working_accumulator))
    else $error("xor file writeback wrong");
  chk_dir_load: assert property (dl && insn[2:0] == 3'h7 |=>
    dir_reg_2 == $past(working_accumulator)) else $error("direction load wrong");
  chk_data_map: assert property (data_hit == (data_addr inside {[7'h05:7'h07]})
    && (data_hit || data_rdata == 8'h00)) else $error("data map wrong");
endmodule : exec_monitor
`default_nettype wire

// >>> verification/file_model.sv
// Register file stand-in: combinational read, write on the clock edge.
// Bench preloads mem; untouched entries stay unknown on purpose.
`timescale 1ns/10ps
`default_nettype none
module file_model (
  input  wire logic       sys_clk,
  input  wire logic [6:0] file_addr,
  input  wire logic       file_we,
  input  wire logic [7:0] file_wdata,
  output logic      [7:0] file_rdata
);
  logic [7:0] mem [128];
  assign file_rdata = mem[file_addr];
  always @(posedge sys_clk) if (file_we) mem[file_addr] <= file_wdata;
endmodule : file_model
`default_nettype wire

// >>> verification/tb.sv
// Bench: xor, swap and direction load instructions through the block.
// Assumes file_model as register file; inputs change 1 ns after the edge.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic sys_clk = 0, rstn = 0, insn_valid = 0, data_we = 0, file_we, data_hit, zero_flag;
  logic [13:0] insn = 0;
  logic [6:0] data_addr = 0, file_addr;
  logic [7:0] data_wdata = 0, file_rdata, file_wdata, data_rdata, acc, d0, d1, d2;
  int num_errors = 0, tests_run = 0;
  initial forever #25 sys_clk = ~sys_clk;
  file_model P(.sys_clk, .file_addr, .file_we, .file_wdata, .file_rdata);
  nibble_swap_xor_dir_exec DUT(.sys_clk, .rstn, .insn_valid, .insn, .file_rdata, .file_addr,
    .file_we, .file_wdata, .data_we, .data_addr, .data_wdata, .data_rdata, .data_hit,
    .working_accumulator(acc), .zero_flag, .dir_reg_0(d0), .dir_reg_1(d1), .dir_reg_2(d2));
  task chk(input logic [7:0] g, e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task op(input logic [13:0] i);
    insn = i;
    insn_valid = 1'b1;
    @(posedge sys_clk);
    #1 insn_valid = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : op
  task t_xor;
    op(14'h3ab5);
    op(14'h3aaf);
    chk(acc, 8'h1a);
    chk(zero_flag, 8'h00);
    op(14'h3aaf);
    op(14'h06a1);
    chk(P.mem[33], 8'h1a);
    op(14'h0621);
    chk(acc, 8'haf);
    op(14'h3aaf);
    chk(zero_flag, 8'h01);
    $display("t_xor done");
  endtask : t_xor
  task t_swap;
    op(14'h0e20);
    chk(acc, 8'h5a);
    op(14'h0ea0);
    chk(P.mem[32], 8'h5a);
    chk(zero_flag, 8'h01);
    $display("t_swap done");
  endtask : t_swap
  task t_dir;
    op(14'h0065);
    chk(d0, 8'h5a);
    op(14'h3aff);
    op(14'h0064);
    op(14'h0067);
    chk(d2, 8'ha5);
    chk(d1, 8'hff);
    chk(d0, 8'h5a);
    data_we = 1;
    data_addr = 7'h06;
    data_wdata = 8'h3c;
    @(posedge sys_clk);
    #1 data_we = 0;
    chk(data_rdata, 8'h3c);
    chk(data_hit, 8'h01);
    data_addr = 7'h08;
    #1 chk(data_rdata, 8'h00);
    chk(data_hit, 8'h00);
    $display("t_dir done");
  endtask : t_dir
  task end_sim;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    P.mem[32] = 8'ha5;
    P.mem[33] = 8'haf;
    repeat (12) @(posedge sys_clk);
    #1 rstn = 1;
    repeat (3) @(posedge sys_clk);
    #1 t_xor;
    t_swap;
    t_dir;
    end_sim;
  end
endmodule : tb
bind nibble_swap_xor_dir_exec exec_monitor M(.sys_clk, .rstn, .insn_valid, .file_we, .data_hit,
  .zero_flag, .insn, .data_addr, .file_rdata, .file_wdata, .data_rdata, .working_accumulator,
  .dir_reg_2);
`default_nettype wire
